/* design/eiw_pkg.sv */
// Purpose: Constants for the external interrupt and wake-up block
// Assumes: Core clock of 25 MHz, four interrupt inputs
// Notes: Times are kept in their own unit, cycle counts derived from them
package eiw_pkg;
    localparam int EIW_NUM_IRQ = 4;
    localparam int EIW_CLK_PERIOD_NS = 40;
    // Least assertion time that wakes the device from standby or powerdown
    localparam int EIW_WAKE_MIN_NS = 50;
    // Least time rounds up to whole cycles, never below one
    localparam int EIW_WAKE_CYCLES_RAW =
        (EIW_WAKE_MIN_NS + EIW_CLK_PERIOD_NS - 1) / EIW_CLK_PERIOD_NS;
    localparam int EIW_WAKE_CYCLES = (EIW_WAKE_CYCLES_RAW < 1) ? 1 : EIW_WAKE_CYCLES_RAW;
    localparam logic [2:0] EIW_WAKE_CNT_MAX = 3'(EIW_WAKE_CYCLES);
    // Port bit sharing of each interrupt input
    localparam logic [3:0] EIW_PIN0_PORT = 4'h2;
    localparam logic [3:0] EIW_PIN0_BIT = 4'h2;
    localparam logic [3:0] EIW_PIN1_PORT = 4'h2;
    localparam logic [3:0] EIW_PIN1_BIT = 4'h4;
    localparam logic [3:0] EIW_PIN2_PORT = 4'h3;
    localparam logic [3:0] EIW_PIN2_BIT = 4'h6;
    localparam logic [3:0] EIW_PIN3_PORT = 4'h3;
    localparam logic [3:0] EIW_PIN3_BIT = 4'h7;
    // Power mode codes
    localparam logic [1:0] EIW_MODE_NORMAL = 2'h0;
    localparam logic [1:0] EIW_MODE_IDLE = 2'h1;
    localparam logic [1:0] EIW_MODE_STANDBY = 2'h2;
    localparam logic [1:0] EIW_MODE_POWERDOWN = 2'h3;
    typedef enum logic [2:0] {
        EIW_RUN = 3'b001,
        EIW_IDLE = 3'b010,
        EIW_SLEEP = 3'b100
    } eiw_state_t;
endpackage

/* design/eiw_top.sv */
// Purpose: External interrupt edge capture and power-saving wake-up
// Assumes: Pins and control inputs synchronous to clk; port mux lives outside
// Notes: Half-rate clock is made here and defines the phase-2 sample point
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
module eiw_top
    import eiw_pkg::*;
#(
    parameter int NUM_IRQ = EIW_NUM_IRQ
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Interrupt pins, already taken off the shared port bits
    input wire logic [NUM_IRQ-1:0] ext_irq_pin,
    // Pin configured as special-function input
    input wire logic [NUM_IRQ-1:0] pin_special_fn,
    // Interrupt enables and pending clears from the core
    input wire logic [NUM_IRQ-1:0] irq_enable,
    input wire logic [NUM_IRQ-1:0] pending_clear,
    input wire logic other_irq_enabled_req,
    // Power mode request from the core, one-cycle pulse
    input wire logic mode_req,
    input wire logic [1:0] mode_code,
    // Outputs
    output logic half_rate_clock_output,
    output logic [NUM_IRQ-1:0] irq_pending,
    output logic asleep,
    output logic idle,
    output logic wake_pulse,
    output logic wake_run_isr
);

    ////////////////////////////////////////////////////////////////////////////
    logic [NUM_IRQ-1:0] sync1;
    logic [NUM_IRQ-1:0] sync2;
    logic [NUM_IRQ-1:0] last_sample;
    logic sample_en;
    logic [NUM_IRQ-1:0] rise;
    logic [2:0] wake_cnt [NUM_IRQ];
    logic [NUM_IRQ-1:0] wake_hit;
    logic [NUM_IRQ-1:0] wake_src;
    eiw_state_t state;

    // Half-rate clock, toggles every core cycle for 50% duty
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            half_rate_clock_output <= 1'b0;
        end else begin
            half_rate_clock_output <= ~half_rate_clock_output;
        end
    end

    // Phase 2 is the cycle while the half-rate clock is high
    assign sample_en = half_rate_clock_output;

    // Two-stage synchroniser; first stage feeds only the second
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= '0;
            sync2 <= '0;
        end else begin
            sync1 <= ext_irq_pin;
            sync2 <= sync1;
        end
    end

    // Phase-2 samples kept for edge detection
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_sample <= '0;
        end else if (sample_en) begin
            last_sample <= sync2;
        end
    end

    // A high shorter than one state time may fall between samples
    assign rise = sample_en ? (sync2 & ~last_sample) : '0;

    // Pending bits: set wins over a clear in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            irq_pending <= '0;
        end else if (state == EIW_RUN) begin
            irq_pending <= (irq_pending & ~pending_clear) | rise;
        end else begin
            irq_pending <= irq_pending & ~pending_clear;
        end
    end

    // Wake counters per pin, counting synchronised high cycles while asleep
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IRQ; gi++) begin : g_wake
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    wake_cnt[gi] <= 3'h0;
                end else if (state != EIW_SLEEP || !sync2[gi] || !pin_special_fn[gi]) begin
                    wake_cnt[gi] <= 3'h0;
                end else if (wake_cnt[gi] != EIW_WAKE_CNT_MAX) begin
                    wake_cnt[gi] <= wake_cnt[gi] + 3'h1;
                end
            end
            assign wake_hit[gi] = (wake_cnt[gi] == EIW_WAKE_CNT_MAX);
        end
    endgenerate

    assign wake_src = wake_hit & pin_special_fn;

    // Power state: run, idle, or standby/powerdown sleep
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= EIW_RUN;
        end else begin
            unique case (state)
                EIW_RUN: begin
                    if (mode_req && mode_code == EIW_MODE_IDLE) begin
                        state <= EIW_IDLE;
                    end else if (mode_req && (mode_code == EIW_MODE_STANDBY ||
                                              mode_code == EIW_MODE_POWERDOWN)) begin
                        state <= EIW_SLEEP;
                    end
                end
                EIW_IDLE: begin
                    if (|(irq_pending & irq_enable) || other_irq_enabled_req) begin
                        state <= EIW_RUN;
                    end
                end
                EIW_SLEEP: begin
                    if (|wake_src) begin
                        state <= EIW_RUN;
                    end
                end
                default: state <= EIW_RUN;
            endcase
        end
    end

    // Status and wake outputs, all registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            asleep <= 1'b0;
            idle <= 1'b0;
            wake_pulse <= 1'b0;
            wake_run_isr <= 1'b0;
        end else begin
            asleep <= (state == EIW_SLEEP) && !(|wake_src);
            idle <= (state == EIW_IDLE) &&
                    !(|(irq_pending & irq_enable) || other_irq_enabled_req);
            wake_pulse <= (state == EIW_SLEEP) && (|wake_src);
            // Enabled waker goes to its handler; else resume after sleep op
            wake_run_isr <= (state == EIW_SLEEP) && (|(wake_src & irq_enable));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    // First edge after reset sees the reset value twice, so it is skipped
    half_clk_a: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) |-> half_rate_clock_output != $past(half_rate_clock_output))
        else $error("half-rate clock did not toggle");

    edge_sets_a: assert property (@(posedge clk) disable iff (rst)
        (state == EIW_RUN && sample_en && sync2[0] && !last_sample[0]) |=> irq_pending[0])
        else $error("rising edge did not set pending");

    phase_only_a: assert property (@(posedge clk) disable iff (rst)
        (!sample_en) |=> $stable(last_sample))
        else $error("sample taken outside phase 2");

    sleep_wake_a: assert property (@(posedge clk) disable iff (rst)
        (state == EIW_SLEEP && pin_special_fn[1] && sync2[1]) [*3] |=>
        (wake_pulse || state == EIW_RUN))
        else $error("held interrupt did not wake");

    no_cfg_a: assert property (@(posedge clk) disable iff (rst)
        (state == EIW_SLEEP && !pin_special_fn[2]) |=> !wake_hit[2])
        else $error("unconfigured pin woke device");

    stay_asleep_a: assert property (@(posedge clk) disable iff (rst)
        (state == EIW_SLEEP && !(|wake_src)) |=> asleep && state == EIW_SLEEP)
        else $error("left sleep without a configured waker");

    wake_once_a: assert property (@(posedge clk) disable iff (rst)
        wake_pulse |-> !asleep && state == EIW_RUN)
        else $error("wake pulse while still asleep");

    isr_pair_a: assert property (@(posedge clk) disable iff (rst)
        wake_run_isr |-> wake_pulse)
        else $error("handler request without wake");

    idle_exit_a: assert property (@(posedge clk) disable iff (rst)
        (state == EIW_IDLE && other_irq_enabled_req) |=> state == EIW_RUN)
        else $error("idle not left on enabled interrupt");

    sync_path_a: assert property (@(posedge clk) disable iff (rst)
        rise[0] |-> sample_en && sync2[0] && !$past(sync2[0], 2))
        else $error("edge not from low-then-high phase-2 samples");

    // Edges seen in idle or sleep must leave the pending bits alone
    no_set_a: assert property (@(posedge clk) disable iff (rst)
        (state != EIW_RUN && !irq_pending[0]) |=> !irq_pending[0])
        else $error("pending set outside normal mode");

    pend_hold_a: assert property (@(posedge clk) disable iff (rst)
        (irq_pending[2] && !pending_clear[2]) |=> irq_pending[2])
        else $error("pending bit dropped without clear");

    clear_lose_a: assert property (@(posedge clk) disable iff (rst)
        (state == EIW_RUN && rise[1] && pending_clear[1]) |=> irq_pending[1])
        else $error("set lost against clear");

endmodule

/* sim/eiw_src_model.sv */
// Purpose: External logic that drives the interrupt request pins
// Assumes: One pulse on fire starts a high period on that pin
// Notes: HOLD below 2 cycles could be missed by the phase-2 sampling
`timescale 1ns/10ps
module eiw_src_model #(
    parameter int HOLD = 3
) (
    // Clock, reset and trigger from the bench
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] fire,
    // Pins toward the block
    output logic [3:0] pins
);
    logic [3:0] cnt [4];
    // Hold each pin high HOLD cycles: at least one state time and 50 ns
    always_ff @(posedge clk or posedge rst) begin
        for (int i = 0; i < 4; i++) begin
            if (rst) begin
                pins[i] <= 1'b0;
                cnt[i] <= 4'h0;
            end else if (fire[i]) begin
                pins[i] <= 1'b1;
                cnt[i] <= 4'(HOLD);
            end else if (cnt[i] > 4'h1) begin
                cnt[i] <= cnt[i] - 4'h1;
            end else begin
                pins[i] <= 1'b0; // Driven low when idle, never left floating
                cnt[i] <= 4'h0;
            end
        end
    end
endmodule

/* sim/tb.sv */
// Purpose: Self-checking bench for interrupt capture and wake-up
// Assumes: Inputs change 1 ns after the rising edge
// Notes: Expected pending bits come from an integer mask kept here
`timescale 1ns/10ps
module tb;
    import eiw_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] fire = 4'h0, spec = 4'h0, en = 4'h0, clr = 4'h0;
    logic oth = 1'b0, mreq = 1'b0;
    logic [1:0] mcode = 2'h0;
    logic [3:0] pins, pend;
    logic hclk, asleep, idle, wk, wk_isr, prev, saw;
    int n_fail = 0, n_compared = 0, exp_pend = 0, m;
    always #20 clk = ~clk;
    eiw_src_model #(.HOLD(3)) src (.clk(clk), .rst(rst), .fire(fire), .pins(pins));
    eiw_top dut (.clk(clk), .rst(rst), .ext_irq_pin(pins), .pin_special_fn(spec),
        .irq_enable(en), .pending_clear(clr), .other_irq_enabled_req(oth),
        .mode_req(mreq), .mode_code(mcode), .half_rate_clock_output(hclk),
        .irq_pending(pend), .asleep(asleep), .idle(idle), .wake_pulse(wk),
        .wake_run_isr(wk_isr));
    ////////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic restart();
        rst = 1'b1;
        tick(16);
        rst = 1'b0;
        exp_pend = 0;
        tick(2);
    endtask
    task automatic close_out();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Fire a pin in a power mode and watch for the wake pulse
    task automatic nap(input logic [1:0] code, input logic [3:0] sp, input logic [3:0] f,
        input logic wake, input logic isr);
        spec = sp;
        en = isr ? f : 4'h0; // Disabled waker must still wake
        mcode = code;
        mreq = 1'b1;
        tick(1);
        mreq = 1'b0;
        tick(3);
        check(asleep, 1'b1);
        saw = 1'b0;
        fire = f;
        tick(1);
        fire = 4'h0;
        repeat (12) begin
            if (wk === 1'b1) begin
                saw = 1'b1;
                check(wk_isr, isr);
            end
            tick(1);
        end
        check(saw, wake);
        check(asleep, !wake);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'h5423));
        restart();
        // Half-rate clock alternates every core cycle, giving 50% duty
        repeat (6) begin
            prev = hclk;
            tick(1);
            check(hclk, !prev);
        end
        // Each pin lands in its own pending bit, then random pin groups
        for (int i = 0; i < 8; i++) begin
            m = (i < 4) ? (1 << i) : $urandom_range(1, 15);
            fire = 4'(m);
            tick(1);
            fire = 4'h0;
            exp_pend |= m;
            tick(8);
            check(pend, 8'(exp_pend));
            m = $urandom_range(0, 15);
            clr = 4'(m);
            tick(1);
            clr = 4'h0;
            exp_pend &= ~m;
            tick(1);
            check(pend, 8'(exp_pend));
        end
        // Clear timed onto the edge's own phase-2 cycle: the set must win
        prev = hclk;
        fire = 4'h2;
        tick(1);
        fire = 4'h0;
        tick(prev ? 3 : 2);
        clr = 4'h2;
        tick(1);
        clr = 4'h0;
        tick(2);
        exp_pend |= 2;
        check(pend, 8'(exp_pend));
        // Idle ignores edges, leaves on another enabled interrupt
        restart();
        mcode = EIW_MODE_IDLE;
        mreq = 1'b1;
        tick(1);
        mreq = 1'b0;
        fire = 4'h5;
        tick(1);
        fire = 4'h0;
        tick(8);
        check(idle, 1'b1);
        check(pend, 8'h0);
        oth = 1'b1;
        tick(4);
        oth = 1'b0;
        check(idle, 1'b0);
        // Standby and powerdown, with and without special-function pins
        restart();
        nap(EIW_MODE_STANDBY, 4'h2, 4'h2, 1'b1, 1'b0);
        nap(EIW_MODE_POWERDOWN, 4'h8, 4'h8, 1'b1, 1'b1);
        nap(EIW_MODE_STANDBY, 4'hb, 4'h4, 1'b0, 1'b1);
        close_out();
    end
    // Watchdog, far beyond the few hundred cycles the run needs
    initial begin
        #400000;
        n_fail++;
        close_out();
    end
endmodule
